// ==== hw/pmc_pkg.sv ====
// package: register map, field positions and timing for power/clock control
package pmc_pkg;
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  // system_mode_reg fields
  localparam int MODE_DIV_LSB = 5;
  localparam int MODE_LOW_READY = 3;
  localparam int MODE_HIGH_READY = 2;
  localparam int MODE_IDLE_EN = 1;
  localparam int MODE_HIGH_SEL = 0;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] MODE_WMASK = 8'he3;
  // power_clock_control fields
  localparam int CTRL_IDLE_SYSCLK = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  // status fields
  localparam int STAT_PDF = 1;
  localparam int STAT_TO = 0;
  localparam logic [1:0] STAT_RESET = 2'h0;
  // divider codes that mean the low-speed oscillator
  localparam logic [2:0] DIV_SUB0 = 3'h0;
  localparam logic [2:0] DIV_SUB1 = 3'h1;
  // high oscillator settle: 16 cycles covers the 15~16 range
  localparam int HOSC_SETTLE_CYC = 16;
  localparam int LOSC_SETTLE_CYC = 2;
  typedef enum logic [1:0] {
    PM_RUN, PM_SLEEP, PM_IDLE_CLOCK_STOPPED, PM_IDLE_CLOCK_RUNNING
  } power_state_t;
endpackage

// ==== hw/osc_ready_timer.sv ====
// settle counter for one oscillator: ready N+1 cycles after run rises
`timescale 1ns/10ps
`default_nettype none
module osc_ready_timer #(
  parameter int CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic ready
);
  logic [5:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
    end else if (!run) begin
      cnt_q <= 6'h00;
    end else if (cnt_q != 6'(CYCLES)) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= run && (cnt_q == 6'(CYCLES));
    end
  end
endmodule
`default_nettype wire

// ==== hw/wdt_gate.sv ====
// watchdog clear/run control derived from the power state
`timescale 1ns/10ps
`default_nettype none
module wdt_gate
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic halt,
  input wire logic enter_sleep,
  input wire logic wake,
  output logic wdt_clear,
  output logic wdt_run
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= halt;
    end
  end
  // held stopped for the whole of sleep; idle keeps counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_run <= 1'b1;
    end else if (enter_sleep) begin
      wdt_run <= 1'b0;
    end else if (wake) begin
      wdt_run <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== hw/power_mode_clock_control.sv ====
// power-mode and system-clock control with its register file
// What this block does
// - halt, idle, clock enable: cpu stops, clock runs
// - halt, idle, no clock enable: idle with system clock stopped, sub clock running
// - halt without idle enable enters sleep
// - idle clock enable is bit 7, resets 0
// - sleep stops clocks, clears and holds watchdog
// - a halt taken in run sets power-down, clears timeout flag
// - high ready flag after oscillator settles
// - divider 000/001 with high select clear runs low oscillator, stops high
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module power_mode_clock_control
  import pmc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic HALT,
  input wire logic WAKE,
  input wire logic WDT_TIMEOUT,
  input wire logic CLR_WDT,
  output logic CPU_CLK_EN,
  output logic SYSCLK_EN,
  output logic SUBCLK_EN,
  output logic HOSC_EN,
  output logic SYSCLK_FULL,
  output logic [2:0] SYSCLK_DIV,
  output logic WDT_CLEAR,
  output logic WDT_RUN,
  output logic [1:0] POWER_STATE
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic pdf_q;
  logic to_q;
  power_state_t state_q;
  logic high_ready;
  logic low_ready;
  logic wdt_clear_w;
  logic wdt_run_w;
  logic slow_src;
  logic hosc_run;
  logic enter_sleep;
  logic waking;
  power_state_t state_d;
  logic [7:0] mode_d;
  logic [7:0] ctrl_d;
  logic [7:0] rdata_d;
  logic halt_take;
  logic in_run;
  logic in_idle_clock_running;
  logic in_sleep;

  // state decodes shared by the output flops
  assign in_run = (state_q == PM_RUN);
  assign in_idle_clock_running = (state_q == PM_IDLE_CLOCK_RUNNING);
  assign in_sleep = (state_q == PM_SLEEP);
  // a halt only counts while running; a repeat halt is ignored
  assign halt_take = HALT && in_run;
  assign waking = WAKE && (state_q != PM_RUN);
  assign enter_sleep = HALT && (state_q == PM_RUN) &&
    !mode_q[MODE_IDLE_EN];
  assign slow_src = !mode_q[MODE_HIGH_SEL] &&
    ((mode_q[7:5] == DIV_SUB0) || (mode_q[7:5] == DIV_SUB1));
  // high oscillator off in slow mode and in sleep/idle_clock_stopped
  assign hosc_run = !slow_src &&
    (state_q == PM_RUN || state_q == PM_IDLE_CLOCK_RUNNING);

  ////////////////////////////////////////////////////////////////////////
  // read-only and unused bits are masked off on the way in
  always_comb begin
    mode_d = mode_q;
    if (WR && ADDR == ADDR_MODE) begin
      mode_d = WDATA & MODE_WMASK;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // bit 6 is never stored, so it always reads zero
  always_comb begin
    ctrl_d = ctrl_q;
    if (WR && ADDR == ADDR_CTRL) begin
      ctrl_d = WDATA & CTRL_WMASK;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // halt sets power-down and wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pdf_q <= STAT_RESET[STAT_PDF];
    end else if (halt_take) begin
      pdf_q <= 1'b1;
    end else if (CLR_WDT) begin
      pdf_q <= 1'b0;
    end
  end

  // a timeout beside a clear leaves the timeout flag set
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      to_q <= STAT_RESET[STAT_TO];
    end else if (halt_take) begin
      to_q <= 1'b0;
    end else if (WDT_TIMEOUT) begin
      to_q <= 1'b1;
    end else if (CLR_WDT) begin
      to_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // halt is looked at only in run; wake only outside it
  always_comb begin
    state_d = state_q;
    case (state_q)
      PM_RUN: begin
        if (HALT) begin
          if (!mode_q[MODE_IDLE_EN]) begin
            state_d = PM_SLEEP;
          end else if (ctrl_q[CTRL_IDLE_SYSCLK]) begin
            state_d = PM_IDLE_CLOCK_RUNNING;
          end else begin
            state_d = PM_IDLE_CLOCK_STOPPED;
          end
        end
      end
      PM_SLEEP, PM_IDLE_CLOCK_STOPPED, PM_IDLE_CLOCK_RUNNING: begin
        if (WAKE) begin
          state_d = PM_RUN;
        end
      end
      default: state_d = PM_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= PM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  osc_ready_timer #(.CYCLES(HOSC_SETTLE_CYC)) u_high_timer (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .run(hosc_run),
    .ready(high_ready)
  );

  wdt_gate u_wdt (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .halt(halt_take),
    .enter_sleep(enter_sleep),
    .wake(waking),
    .wdt_clear(wdt_clear_w),
    .wdt_run(wdt_run_w)
  );

  // low oscillator is treated as always running outside sleep
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_ready <= 1'b0;
    end else begin
      low_ready <= (state_q != PM_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // every enable lags the state by one flop so the pins never glitch
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CPU_CLK_EN <= 1'b1;
    end else begin
      CPU_CLK_EN <= in_run;
    end
  end

  // idle_clock_stopped drops the system clock, idle_clock_running keeps peripherals clocked
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SYSCLK_EN <= 1'b1;
    end else begin
      SYSCLK_EN <= in_run || in_idle_clock_running;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SUBCLK_EN <= 1'b1;
    end else begin
      SUBCLK_EN <= !in_sleep;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HOSC_EN <= 1'b1;
    end else begin
      HOSC_EN <= hosc_run;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SYSCLK_FULL <= 1'b1;
    end else begin
      SYSCLK_FULL <= mode_q[MODE_HIGH_SEL];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SYSCLK_DIV <= 3'h0;
    end else begin
      SYSCLK_DIV <= mode_q[7:5];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      POWER_STATE <= 2'h0;
    end else begin
      POWER_STATE <= state_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WDT_CLEAR <= 1'b0;
    end else begin
      WDT_CLEAR <= wdt_clear_w;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WDT_RUN <= 1'b1;
    end else begin
      WDT_RUN <= wdt_run_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // idle cycles return zero so the read bus can be or-combined
  always_comb begin
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        ADDR_MODE: begin
          rdata_d = mode_q;
          rdata_d[MODE_HIGH_READY] = high_ready;
          rdata_d[MODE_LOW_READY] = low_ready;
        end
        ADDR_CTRL: rdata_d = ctrl_q;
        ADDR_STATUS: rdata_d = {6'h00, pdf_q, to_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ==== sim/power_mode_clock_control_chk.sv ====
// checker: port-level assertions for power and clock control
`timescale 1ns/10ps
`default_nettype none
module pmcc_chk (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic HALT,
  input wire logic WAKE,
  input wire logic CPU_CLK_EN,
  input wire logic SYSCLK_EN,
  input wire logic SUBCLK_EN,
  input wire logic HOSC_EN,
  input wire logic SYSCLK_FULL,
  input wire logic [2:0] SYSCLK_DIV,
  input wire logic WDT_CLEAR,
  input wire logic WDT_RUN,
  input wire logic [1:0] POWER_STATE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // state output lags one cycle, so guard against a change just before
  sequence halt_go;
    HALT && !$past(HALT) && POWER_STATE == 2'h0;
  endsequence
  sequence wake_go;
    WAKE && !$past(WAKE) && POWER_STATE != 2'h0;
  endsequence
  AST_HALT_CPU: assert property (
    halt_go |-> ##2 !CPU_CLK_EN && POWER_STATE != 2'h0)
    else $error("halt left cpu clock on");
  AST_HALT_WDT: assert property (
    halt_go |-> ##2 WDT_CLEAR ##1 !WDT_CLEAR)
    else $error("watchdog clear pulse wrong");
  AST_IDLE_CLOCK_RUNNING: assert property (
    POWER_STATE == 2'h3 |-> SYSCLK_EN && SUBCLK_EN && !CPU_CLK_EN)
    else $error("idle with clock has wrong enables");
  AST_IDLE_CLOCK_STOPPED: assert property (
    POWER_STATE == 2'h2 |-> !SYSCLK_EN && SUBCLK_EN && !HOSC_EN)
    else $error("idle without clock has wrong enables");
  AST_SLEEP: assert property (
    POWER_STATE == 2'h1 |-> !SYSCLK_EN && !SUBCLK_EN && !WDT_RUN)
    else $error("sleep left a clock or watchdog running");
  AST_WAKE: assert property (
    wake_go |-> ##2 WDT_RUN && CPU_CLK_EN && POWER_STATE == 2'h0)
    else $error("wake did not restore run");
  AST_SLOW: assert property (
    !SYSCLK_FULL && SYSCLK_DIV <= 3'h1 && $stable(SYSCLK_DIV)
    && $stable(SYSCLK_FULL) |-> !HOSC_EN)
    else $error("high oscillator runs on slow source");
  AST_FULL: assert property (
    SYSCLK_FULL && $stable(SYSCLK_FULL) && POWER_STATE == 2'h0 |-> HOSC_EN)
    else $error("full clock without high oscillator");
endmodule
////////////////////////////////////////////////////////////////////////
bind power_mode_clock_control pmcc_chk i_chk (.*);
`default_nettype wire

// ==== sim/test_power_mode_clock_control.sv ====
// testbench: power mode and system clock control
`timescale 1ns/10ps
`default_nettype none
module test_power_mode_clock_control;
  import pmc_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00, RDATA, d;
  logic WR = 1'b0, RD = 1'b0, HALT = 1'b0, WAKE = 1'b0;
  logic WDT_TIMEOUT = 1'b0, CLR_WDT = 1'b0;
  logic CPU_CLK_EN, SYSCLK_EN, SUBCLK_EN, HOSC_EN, SYSCLK_FULL;
  logic WDT_CLEAR, WDT_RUN;
  logic [2:0] SYSCLK_DIV;
  logic [1:0] POWER_STATE;
  int err_total = 0, checked = 0;
  always #50 SYS_CLK = ~SYS_CLK;
  power_mode_clock_control i_power_mode_clock_control (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge SYS_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // one-cycle pulse: 0 halt, 1 wake, 2 timeout, 3 watchdog clear
  task automatic pulse(input int k);
    @(posedge SYS_CLK);
    {HALT, WAKE, WDT_TIMEOUT, CLR_WDT} <= 4'h8 >> k;
    @(posedge SYS_CLK);
    {HALT, WAKE, WDT_TIMEOUT, CLR_WDT} <= 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(ADDR_MODE);
    chk(d & MODE_WMASK, 8'h01);
    rd(ADDR_CTRL);
    chk(d, 8'h00);
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL);
    chk(d, 8'hbf);
    wr(2'h3, 8'hff);
    rd(2'h3);
    chk(d, 8'h00);
    wr(ADDR_CTRL, 8'h00);
  endtask
  task automatic t_halt(input logic ie, fs, input logic [1:0] st);
    wr(ADDR_MODE, {6'h0, ie, 1'b1});
    wr(ADDR_CTRL, {fs, 7'h0});
    pulse(2);
    rd(ADDR_STATUS);
    chk(d, 8'h01);
    pulse(0);
    repeat (2) @(posedge SYS_CLK);
    #1 chk({CPU_CLK_EN, SYSCLK_EN, SUBCLK_EN, HOSC_EN, WDT_RUN,
      POWER_STATE}, {1'b0, st == 2'h3, st != 2'h1, st == 2'h3,
      st != 2'h1, st});
    rd(ADDR_STATUS);
    chk(d, 8'h02);
    pulse(1);
    repeat (2) @(posedge SYS_CLK);
    #1 chk({CPU_CLK_EN, POWER_STATE}, 8'h04);
    pulse(3);
  endtask
  task automatic t_slow;
    wr(ADDR_MODE, 8'h20);
    repeat (2) @(posedge SYS_CLK);
    #1 chk({HOSC_EN, SYSCLK_FULL, SYSCLK_DIV}, 8'h01);
    rd(ADDR_MODE);
    chk(d[2], 1'b0);
    wr(ADDR_MODE, 8'h40);
    repeat (12) @(posedge SYS_CLK);
    #1 chk({HOSC_EN, SYSCLK_FULL, SYSCLK_DIV}, 8'h12);
    rd(ADDR_MODE);
    chk(d[2], 1'b0);
    repeat (8) @(posedge SYS_CLK);
    rd(ADDR_MODE);
    chk(d[2], 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    t_regs;
    // clock enable set must not turn a plain halt into idle
    t_halt(1'b0, 1'b1, 2'h1);
    t_halt(1'b1, 1'b0, 2'h2);
    t_halt(1'b1, 1'b1, 2'h3);
    t_slow;
    summarize;
  end
  initial begin
    repeat (3000) @(posedge SYS_CLK);
    err_total++;
    summarize;
  end
endmodule
`default_nettype wire
